// file: logic/frd_dispatch.v
// rom routine dispatcher: decode, latency timing, ready and done for the fpu core
// assumes the issuer keeps the start request only while ready is high,
// and a coprocessor-mode host clock well below half the system clock rate
//
// Summary of operation
// - total states then smaller issue count; next operation accepted only after it.
// - one state is half host clock in coprocessor mode, one clock otherwise.
// - load, save and move-multiple take states depending on words moved.
// - add, subtract, absolute sum and difference take 2 states, issue after 1.
// - compare subtracts, updates status only, 2 states, issue after 1.
// - all precision conversions take 2 states, issue after 1.
// - square root takes 10(9) single and 16(15) double.
// - squaring takes 4(3) single and 5(4) double.
// - abort stops any instruction in progress; 2 states, issue after 1.
// - check reports whether previous instruction finished; 2 states, issue after 1.
// - matrix row multiply elements 3-0 takes 6(5) single, 11(10) double.
// - matrix steps 11-8 and 15-12 take 12(11), double 16(15).
// - matrix add step takes 9(8) in every precision.
// - dot product 7(6) integer and single, 10(9) double.
// - cross product 9(8) integer and single, 15(14) double.
// - magnitude 30/20/29, normalize 50/31/49, issue one earlier.
// - reflection 16(15) integer and single, 23(22) double.
// - backface test 16(15) single, 25(24) double.
// - x-plane line clip 25(24) single, 35(34) double.
// - viewport scale-convert 21(20) single, 33(32) double.
// - point-window 5(4), point-volume 7(6), both precisions.
// - vertex-volume compare 6(5), line clip value compare 5(4).
// - pair min/max 5(4) in single and double.
// - vector scaling 4(3) single, 7(6) double.
`timescale 1ns/1ps
`include "frd_map.vh"

module frd_dispatch
(
	input wire CLK_SYS_IN,
	input wire SYS_RST_IN,
	input wire COPROC_MODE_IN,
	input wire HOST_CLK_IN,
	input wire START_IN,
	input wire INT_SELECT_IN,
	input wire [`FRD_ADDR_W-1:0] ROUTINE_ADDR_IN,
	input wire [`FRD_CNT_W-1:0] XFER_WORDS_IN,
	output wire READY_OUT,
	output reg DONE_OUT,
	output reg BUSY_OUT,
	output reg [1:0] PRECISION_OUT,
	output reg [`FRD_ADDR_W-1:0] ACTIVE_ADDR_OUT,
	output reg STATUS_ONLY_OUT,
	output reg ABORT_OUT,
	output reg CHECK_RESULT_OUT,
	output reg CHECK_VALID_OUT,
	output reg RESTRICT_ERR_OUT,
	output reg ACCEPT_OUT
);

// ==========================================
// decode
wire [`FRD_CNT_W-1:0] rom_total;
wire [`FRD_CNT_W-1:0] rom_issue;
wire [`FRD_CLS_W-1:0] rom_cls;
wire rom_restricted;
wire tick;

frd_latency_rom u_rom
(
	.addr_in(ROUTINE_ADDR_IN),
	.total_out(rom_total),
	.issue_out(rom_issue),
	.cls_out(rom_cls),
	.restricted_out(rom_restricted)
);

frd_state_tick u_tick
(
	.clk_in(CLK_SYS_IN),
	.rst_in(SYS_RST_IN),
	.coproc_mode_in(COPROC_MODE_IN),
	.host_clk_in(HOST_CLK_IN),
	.tick_out(tick)
);

// in host-independent mode only a jump with internal select reaches the rom
wire selected = COPROC_MODE_IN | INT_SELECT_IN;
wire in_range = (ROUTINE_ADDR_IN >= `FRD_INT_LO && ROUTINE_ADDR_IN <= `FRD_INT_HI) ||
	(ROUTINE_ADDR_IN >= `FRD_SGL_LO && ROUTINE_ADDR_IN <= `FRD_DBL_HI);
wire is_nop = (rom_cls == `FRD_CLS_NOP) || !in_range;
wire refused = !COPROC_MODE_IN && rom_restricted;

// variable transfer latency: base states plus one per word
wire [`FRD_CNT_W-1:0] xfer_total = `FRD_XFER_BASE + XFER_WORDS_IN;
wire [`FRD_CNT_W-1:0] sel_total = (rom_cls == `FRD_CLS_XFER) ? xfer_total : rom_total;
wire [`FRD_CNT_W-1:0] sel_issue = (rom_cls == `FRD_CLS_XFER) ? xfer_total - 8'h01 : rom_issue;

// ==========================================
// timing
reg [`FRD_CNT_W-1:0] elapsed;
reg [`FRD_CNT_W-1:0] total;
reg [`FRD_CNT_W-1:0] issue;
reg issue_open;
reg prev_done;

assign READY_OUT = issue_open;
wire take = START_IN && issue_open && selected;
wire launch = take && !is_nop && !refused;
wire [`FRD_CNT_W-1:0] next_elapsed = elapsed + 8'h01;

always @(posedge CLK_SYS_IN)
begin
	if (SYS_RST_IN)
	begin
		elapsed <= 8'h00;
		total <= 8'h00;
		issue <= 8'h00;
		issue_open <= 1'b1;
		prev_done <= 1'b1;
		DONE_OUT <= 1'b0;
		BUSY_OUT <= 1'b0;
		PRECISION_OUT <= `FRD_PREC_INT;
		ACTIVE_ADDR_OUT <= 9'h000;
		STATUS_ONLY_OUT <= 1'b0;
		ABORT_OUT <= 1'b0;
		CHECK_RESULT_OUT <= 1'b0;
		CHECK_VALID_OUT <= 1'b0;
		RESTRICT_ERR_OUT <= 1'b0;
		ACCEPT_OUT <= 1'b0;
	end
	else
	begin
		DONE_OUT <= 1'b0;
		ABORT_OUT <= 1'b0;
		CHECK_VALID_OUT <= 1'b0;
		ACCEPT_OUT <= take;
		RESTRICT_ERR_OUT <= take && refused;
		if (launch)
		begin
			elapsed <= 8'h00;
			total <= sel_total;
			issue <= sel_issue;
			issue_open <= 1'b0;
			BUSY_OUT <= 1'b1;
			ACTIVE_ADDR_OUT <= ROUTINE_ADDR_IN;
			STATUS_ONLY_OUT <= (rom_cls == `FRD_CLS_CMP);
			if (ROUTINE_ADDR_IN < `FRD_SGL_LO)
				PRECISION_OUT <= `FRD_PREC_INT;
			else if (ROUTINE_ADDR_IN < `FRD_DBL_LO)
				PRECISION_OUT <= `FRD_PREC_SGL;
			else
				PRECISION_OUT <= `FRD_PREC_DBL;
			if (rom_cls == `FRD_CLS_ABORT)
				ABORT_OUT <= 1'b1;
			if (rom_cls == `FRD_CLS_CHECK)
			begin
				CHECK_VALID_OUT <= 1'b1;
				CHECK_RESULT_OUT <= prev_done;
			end
			// every launch, abort included, replaces the running routine, so its completion is never reported
			prev_done <= 1'b0;
		end
		else if (BUSY_OUT && tick)
		begin
			elapsed <= next_elapsed;
			if (next_elapsed == issue)
				issue_open <= 1'b1;
			if (next_elapsed == total)
			begin
				DONE_OUT <= 1'b1;
				BUSY_OUT <= 1'b0;
				prev_done <= 1'b1;
			end
		end
	end
end

endmodule

// file: logic/frd_latency_rom.v
// latency and class lookup for the internal rom routines
// assumes a routine address in the 9-bit internal space; combinational only
`timescale 1ns/1ps
`include "frd_map.vh"

module frd_latency_rom
(
	input wire [`FRD_ADDR_W-1:0] addr_in,
	output reg [`FRD_CNT_W-1:0] total_out,
	output reg [`FRD_CNT_W-1:0] issue_out,
	output reg [`FRD_CLS_W-1:0] cls_out,
	output reg restricted_out
);

// ==========================================
// table: total states, issue count is total minus one for every nonzero total, zero otherwise
reg [`FRD_CNT_W-1:0] t;

always @*
begin
	t = 8'h00;
	cls_out = `FRD_CLS_FIXED;
	restricted_out = 1'b0;
	case (addr_in)
	9'h035: t = 8'h0a;
	9'h036, 9'h037: t = 8'h0c;
	9'h038, 9'h0b8, 9'h0f8: t = 8'h09;
	9'h039, 9'h03a, 9'h0b9, 9'h0ba, 9'h0f9, 9'h0fa: t = 8'h04;
	9'h03b, 9'h0bb: t = 8'h07;
	9'h0fb: t = 8'h0a;
	9'h03c, 9'h0bc: t = 8'h09;
	9'h0fc: t = 8'h0f;
	9'h03d: t = 8'h1e;
	9'h0bd: t = 8'h14;
	9'h0fd: t = 8'h1d;
	9'h03e: t = 8'h32;
	9'h0be: t = 8'h1f;
	9'h0fe: t = 8'h31;
	9'h03f, 9'h0bf: t = 8'h10;
	9'h0ff: t = 8'h17;
	9'h080, 9'h081, 9'h083, 9'h084, 9'h085, 9'h08b,
	9'h0c0, 9'h0c1, 9'h0c3, 9'h0c4, 9'h0c5, 9'h0cb: t = 8'h02;
	9'h082, 9'h0c2:
	begin
		t = 8'h02;
		cls_out = `FRD_CLS_CMP;
	end
	9'h088, 9'h093, 9'h0a0, 9'h0a1, 9'h0a2, 9'h0a3, 9'h0ac,
	9'h0d3, 9'h0e0, 9'h0e1, 9'h0e2, 9'h0e3, 9'h0ec: t = 8'h02;
	9'h0a4, 9'h0a5, 9'h0a6, 9'h0e4, 9'h0e5, 9'h0e6: t = 8'h02;
	9'h089, 9'h08a: t = 8'h07;
	9'h086, 9'h087, 9'h08d, 9'h08e, 9'h0c6, 9'h0c7, 9'h0cd, 9'h0ce, 9'h0ae, 9'h0af:
	begin
		cls_out = `FRD_CLS_XFER;
		restricted_out = (addr_in != 9'h086) && (addr_in != 9'h087);
	end
	9'h090, 9'h0d0: t = 8'h05;
	9'h091, 9'h0d1: t = 8'h07;
	9'h092: t = 8'h10;
	9'h0d2: t = 8'h19;
	9'h094: t = 8'h11;
	9'h095, 9'h096: t = 8'h19;
	9'h0d5, 9'h0d6: t = 8'h23;
	9'h097, 9'h09c: t = 8'h12;
	9'h098: t = 8'h15;
	9'h0d8: t = 8'h21;
	9'h099, 9'h0d9: t = 8'h0d;
	9'h09a, 9'h0da: t = 8'h06;
	9'h09d, 9'h0dd: t = 8'h05;
	9'h09b: t = 8'h11;
	9'h09e: t = 8'h16;
	9'h0a7:
	begin
		t = 8'h04;
		restricted_out = 1'b1;
	end
	9'h0e7:
	begin
		t = 8'h07;
		restricted_out = 1'b1;
	end
	9'h0a8: t = 8'h04;
	9'h0e8: t = 8'h05;
	9'h0a9, 9'h0aa: t = 8'h0a;
	9'h0e9, 9'h0ea: t = 8'h10;
	9'h0ab, 9'h0eb:
	begin
		t = 8'h02;
		cls_out = `FRD_CLS_ABORT;
	end
	9'h0ad, 9'h0ed:
	begin
		t = 8'h02;
		cls_out = `FRD_CLS_CHECK;
	end
	9'h0b0, 9'h0b1, 9'h0f0, 9'h0f1, 9'h0b2, 9'h0f2, 9'h0b3, 9'h0f3:
	begin
		restricted_out = 1'b1;
		t = (addr_in[1:0] == 2'h2) ? 8'h03 :
			((addr_in[1:0] == 2'h3) ? 8'h05 : ((addr_in[6]) ? 8'h05 : 8'h04));
	end
	9'h0b4: t = 8'h06;
	9'h0f4: t = 8'h0b;
	9'h0b5: t = 8'h0a;
	9'h0f5: t = 8'h0e;
	9'h0b6, 9'h0b7: t = 8'h0c;
	9'h0f6, 9'h0f7: t = 8'h10;
	9'h0c8: t = 8'h03;
	9'h0c9, 9'h0ca: t = 8'h0d;
	9'h0d4: t = 8'h1a;
	9'h0d7: t = 8'h1c;
	9'h0db, 9'h0dc, 9'h0de: t = 8'h1f;
	default:
	begin
		t = 8'h00;
		cls_out = `FRD_CLS_NOP;
	end
	endcase
	total_out = t;
	issue_out = (t == 8'h00) ? 8'h00 : t - 8'h01;
end

endmodule

// file: logic/frd_map.vh
// constants for the rom routine dispatcher: routine addresses, classes, latencies
// assumes inclusion by the dispatcher modules only
`ifndef FRD_MAP_VH
`define FRD_MAP_VH

// ==========================================
// address fields
`define FRD_ADDR_W 9
`define FRD_INT_LO 9'h035
`define FRD_INT_HI 9'h03f
`define FRD_SGL_LO 9'h080
`define FRD_DBL_LO 9'h0c0
`define FRD_DBL_HI 9'h0ff

// ==========================================
// routine classes
`define FRD_CLS_W 3
`define FRD_CLS_NOP 3'h0
`define FRD_CLS_FIXED 3'h1
`define FRD_CLS_XFER 3'h2
`define FRD_CLS_ABORT 3'h3
`define FRD_CLS_CHECK 3'h4
`define FRD_CLS_CMP 3'h5

// ==========================================
// precision codes
`define FRD_PREC_INT 2'h0
`define FRD_PREC_SGL 2'h1
`define FRD_PREC_DBL 2'h2

// ==========================================
// state counts
`define FRD_CNT_W 8
`define FRD_XFER_BASE 8'h02

`endif

// file: logic/frd_state_tick.v
// machine-state tick generator
// assumes host_mode is steady while idle; one tick per state
`timescale 1ns/1ps
`include "frd_map.vh"

module frd_state_tick
(
	input wire clk_in,
	input wire rst_in,
	input wire coproc_mode_in,
	input wire host_clk_in,
	output reg tick_out
);

// ==========================================
// coprocessor mode: a state on each host clock edge, i.e. half a period
reg sync_a;
reg sync_b;
reg last;

always @(posedge clk_in)
begin
	if (rst_in)
	begin
		sync_a <= 1'b0;
		sync_b <= 1'b0;
		last <= 1'b0;
		tick_out <= 1'b0;
	end
	else
	begin
		sync_a <= host_clk_in;
		sync_b <= sync_a;
		last <= sync_b;
		tick_out <= coproc_mode_in ? (sync_b ^ last) : 1'b1;
	end
end

endmodule

// file: verif/frd_dispatch_asserts.sv
// port checker for the rom routine dispatcher
// assumes binding onto frd_dispatch with its port names
`timescale 1ns/1ps
module frd_dispatch_asserts
(
	input wire CLK_SYS_IN,
	input wire SYS_RST_IN,
	input wire COPROC_MODE_IN,
	input wire START_IN,
	input wire INT_SELECT_IN,
	input wire [8:0] ROUTINE_ADDR_IN,
	input wire READY_OUT,
	input wire DONE_OUT,
	input wire BUSY_OUT,
	input wire [1:0] PRECISION_OUT,
	input wire [8:0] ACTIVE_ADDR_OUT,
	input wire STATUS_ONLY_OUT,
	input wire ABORT_OUT,
	input wire RESTRICT_ERR_OUT,
	input wire ACCEPT_OUT
);
	// ==========================================
	// take and timing relations
	wire take = START_IN && READY_OUT && (COPROC_MODE_IN || INT_SELECT_IN);
	wire host = take && !COPROC_MODE_IN;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (SYS_RST_IN);
	accept_pulse_a: assert property (take |=> ACCEPT_OUT) else $error("accept missing");
	no_take_a: assert property (!take |=> !ACCEPT_OUT) else $error("accept without take");
	add_issue_a: assert property (host && ROUTINE_ADDR_IN == 9'h080 |=> !READY_OUT ##1 READY_OUT)
		else $error("add issue count wrong");
	sqrt_issue_a: assert property (host && ROUTINE_ADDR_IN == 9'h0a9 |=> !READY_OUT [*8] ##1 !READY_OUT ##1 READY_OUT)
		else $error("root issue count wrong");
	restrict_refuse_a: assert property (host && ROUTINE_ADDR_IN == 9'h0b3 |=> RESTRICT_ERR_OUT && READY_OUT)
		else $error("restricted routine not refused");
	abort_pulse_a: assert property (take && (ROUTINE_ADDR_IN == 9'h0ab || ROUTINE_ADDR_IN == 9'h0eb) |=> ABORT_OUT ##1 !ABORT_OUT)
		else $error("abort pulse wrong");
	compare_flags_a: assert property (take && ROUTINE_ADDR_IN == 9'h082 |=> STATUS_ONLY_OUT && PRECISION_OUT == 2'h1)
		else $error("compare flags wrong");
	double_prec_a: assert property (take && ROUTINE_ADDR_IN == 9'h0e6 |=> PRECISION_OUT == 2'h2 && ACTIVE_ADDR_OUT == 9'h0e6)
		else $error("double precision decode wrong");
	done_ends_busy_a: assert property (DONE_OUT |-> !BUSY_OUT && $past(BUSY_OUT)) else $error("done without busy");
	nop_keep_a: assert property (take && ROUTINE_ADDR_IN == 9'h08c |=> READY_OUT) else $error("reserved address blocked");
endmodule
bind frd_dispatch frd_dispatch_asserts chk
(
	.CLK_SYS_IN(CLK_SYS_IN),
	.SYS_RST_IN(SYS_RST_IN),
	.COPROC_MODE_IN(COPROC_MODE_IN),
	.START_IN(START_IN),
	.INT_SELECT_IN(INT_SELECT_IN),
	.ROUTINE_ADDR_IN(ROUTINE_ADDR_IN),
	.READY_OUT(READY_OUT),
	.DONE_OUT(DONE_OUT),
	.BUSY_OUT(BUSY_OUT),
	.PRECISION_OUT(PRECISION_OUT),
	.ACTIVE_ADDR_OUT(ACTIVE_ADDR_OUT),
	.STATUS_ONLY_OUT(STATUS_ONLY_OUT),
	.ABORT_OUT(ABORT_OUT),
	.RESTRICT_ERR_OUT(RESTRICT_ERR_OUT),
	.ACCEPT_OUT(ACCEPT_OUT)
);

// file: verif/frd_host_model.sv
// host local clock model for coprocessor-mode runs
// assumes the bench raises run_in only around routines of that mode
`timescale 1ns/1ps
module frd_host_model
(
	input wire run_in,
	output logic host_clk_out
);
	initial host_clk_out = 1'b0;
	// each edge is one machine state; stands still when idle
	always #37 if (run_in) host_clk_out = ~host_clk_out;
endmodule

// file: verif/test_fpu_rom_routine_dispatch.sv
// self-checking bench for the rom routine dispatcher
// assumes frd_dispatch, the host model and the bound checker
`timescale 1ns/1ps
module test_fpu_rom_routine_dispatch;
	logic clk, rst, coproc, start, sel, run, host_clk;
	logic ready, done, busy, stat, abo, chr, chv, rerr, acc, a1, e1, b1, v1, r1, d1;
	logic [8:0] addr, act;
	logic [7:0] words;
	logic [1:0] prec;
	logic [31:0] tbl [0:28];
	int fail_count, checks_done, kr, kd, i;
	frd_dispatch dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .COPROC_MODE_IN(coproc), .HOST_CLK_IN(host_clk),
		.START_IN(start), .INT_SELECT_IN(sel), .ROUTINE_ADDR_IN(addr), .XFER_WORDS_IN(words), .READY_OUT(ready),
		.DONE_OUT(done), .BUSY_OUT(busy), .PRECISION_OUT(prec), .ACTIVE_ADDR_OUT(act), .STATUS_ONLY_OUT(stat),
		.ABORT_OUT(abo), .CHECK_RESULT_OUT(chr), .CHECK_VALID_OUT(chv), .RESTRICT_ERR_OUT(rerr), .ACCEPT_OUT(acc));
	frd_host_model host (.run_in(run), .host_clk_out(host_clk));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================
	// shared tasks
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task summarize;
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// launch one routine; kr counts cycles to ready, kd to done
	task launch(input logic [8:0] a, input logic [7:0] w, input bit full);
		@(posedge clk);
		start <= 1'b1;
		addr <= a;
		words <= w;
		@(posedge clk);
		start <= 1'b0;
		#1;
		{a1, e1, b1, v1, r1} = {acc, rerr, abo, chv, chr};
		kr = 0;
		while (ready !== 1'b1 && kr < 300)
		begin
			@(posedge clk);
			#1;
			kr++;
		end
		kd = kr;
		while (full && done !== 1'b1 && kd < 300)
		begin
			@(posedge clk);
			#1;
			kd++;
		end
	endtask
	// second routine taken at the first edge the first allows
	task overlap(input logic [8:0] a, input logic [8:0] b);
		@(posedge clk);
		start <= 1'b1;
		addr <= a;
		@(posedge clk);
		addr <= b;
		kr = 0;
		do
		begin
			@(posedge clk);
			#1;
			kr++;
		end while (acc !== 1'b1 && kr < 60);
		{b1, v1, r1, d1} = {abo, chv, chr, done};
		@(posedge clk);
		start <= 1'b0;
		#1;
		kd = 1;
		while (done !== 1'b1 && kd < 300)
		begin
			@(posedge clk);
			#1;
			kd++;
		end
	endtask
	// ==========================================
	// scenarios
	task t_table;
		for (i = 0; i < 29; i++)
		begin
			launch(tbl[i][28:20], {4'h0, tbl[i][3:0]}, 1'b1);
			chk("ready", kr, {24'h0, tbl[i][11:4]});
			chk("done", kd, {24'h0, tbl[i][19:12]});
			chk("status", stat, tbl[i][28:20] == 9'h082);
			chk("addr busy", {busy, act}, {1'b0, tbl[i][28:20]});
			if (tbl[i][28:20] != 9'h0ab && tbl[i][28:20] != 9'h0ed)
				chk("prec", prec, tbl[i][28:20] < 9'h080 ? 0 : tbl[i][28:20] < 9'h0c0 ? 1 : 2);
		end
	endtask
	task t_refuse;
		@(posedge clk);
		sel <= 1'b0;
		launch(9'h080, 8'h00, 1'b0);
		chk("unselected", {a1, kr[0]}, 2'h0);
		@(posedge clk);
		sel <= 1'b1;
		launch(9'h0b3, 8'h00, 1'b0);
		chk("restrict", {a1, e1, kr[0]}, 3'h6);
		launch(9'h08c, 8'h00, 1'b0);
		chk("reserved", {a1, e1, kr[0]}, 3'h4);
	endtask
	task t_overlap;
		overlap(9'h0e9, 9'h0ab);
		chk("abort", {b1, d1, kd[7:0]}, 10'h202);
		overlap(9'h0ea, 9'h0ad);
		chk("check busy", {v1, r1}, 2'h2);
		launch(9'h080, 8'h00, 1'b1);
		launch(9'h0ad, 8'h00, 1'b1);
		chk("check idle", {v1, r1}, 2'h3);
	endtask
	// reset in mid-run drops the running routine and must reopen issue at once
	task t_reset;
		@(posedge clk);
		start <= 1'b1;
		addr <= 9'h0fe;
		@(posedge clk);
		start <= 1'b0;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("reset state", {ready, busy, done, prec, act}, 14'h2000);
		@(posedge clk);
		#1;
		chk("after reset", {ready, busy, acc, prec, act}, 14'h2000);
		launch(9'h080, 8'h00, 1'b1);
		chk("first after reset", {kr[3:0], kd[3:0]}, 8'h12);
	endtask
	// host clock states are slower than system clocks, so only a window is checked
	task t_coproc;
		@(posedge clk);
		coproc <= 1'b1;
		run <= 1'b1;
		launch(9'h0b3, 8'h00, 1'b1);
		chk("mode err", e1, 1'b0);
		chk("minmax", kd >= 15 && kd <= 30, 1'b1);
		launch(9'h0e7, 8'h00, 1'b1);
		chk("vscale", kd >= 21 && kd <= 38, 1'b1);
		launch(9'h08d, 8'h03, 1'b1);
		chk("move", kd >= 15 && kd <= 30, 1'b1);
		@(posedge clk);
		coproc <= 1'b0;
		run <= 1'b0;
	endtask
	initial
	begin
		{rst, coproc, start, run, sel} = 5'h11;
		addr = 9'h000;
		words = 8'h00;
		fail_count = 0;
		checks_done = 0;
		tbl = '{32'h08002010, 32'h08202010, 32'h0e602010, 32'h0a90a090, 32'h0ea100f0, 32'h0a804030,
			32'h0e805040, 32'h0b406050, 32'h0f40b0a0, 32'h0f7100f0, 32'h0360c0b0, 32'h03809080,
			32'h0fb0a090, 32'h03c09080, 32'h03e32310, 32'h0be1f1e0, 32'h0fd1d1c0, 32'h0ff17160,
			32'h092100f0, 32'h0d219180, 32'h0d523220, 32'h09815140, 32'h09005040, 32'h0d107060,
			32'h09a06050, 32'h09d05040, 32'h0ab02010, 32'h0ed02010, 32'h08605043};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_table;
		t_refuse;
		t_overlap;
		t_reset;
		t_coproc;
		summarize;
	end
	initial
	begin
		#300000;
		fail_count++;
		summarize;
	end
endmodule
